// [inc/timer_d_consts.svh]
// Offsets, field positions, reset values and counts of the 8-bit timer.
// Assumes word-indexed registers on a 32-bit bus: byte address = 4 * index.
`ifndef TIMER_D_CONSTS_SVH
`define TIMER_D_CONSTS_SVH

// ************************************************************
// Register indexes
// ************************************************************
`define IDX_IRQ_FLAG 8'h03
`define IDX_COUNT_MODE_SELECT 8'h10
`define IDX_LOAD_LOW 8'h11
`define IDX_LOAD_HIGH 8'h12
`define IDX_OUTPUT_CAPTURE_MODE 8'h15
`define IDX_CAPTURE_FLAGS 8'h21
`define IDX_EVENT_PIN_FUNCTION 8'h25
`define IDX_EVENT_EDGE_SELECT 8'h27

// ************************************************************
// Field positions
// ************************************************************
`define BIT_IRQ_FLAG 0
`define BIT_CAPTURE_STATUS 0
`define BIT_CAPTURE_ERROR 1
`define BIT_MODE_RELOAD 0
`define BIT_MODE_EXT_EVENT 1
`define BIT_PIN_EVENT_INPUT 0
`define BIT_CAPTURE_ENABLE 3

// ************************************************************
// Reset values and counts
// ************************************************************
`define RST_NIBBLE 4'h0
`define RST_COUNT 8'h00
`define COUNT_MAX 8'hff
`define MODE_DELAY_CYCLES 2'h2

`endif

// [inc/timer_d_pkg.sv]
// Types shared by the timer and its edge detector.
// Assumes the constants header is compiled alongside.
package timer_d_pkg;

  // ************************************************************
  // Bus carriers
  // ************************************************************
  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hready;
    logic [31:0] hwdata;
  } ahb_req_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } ahb_rsp_t;

  // ************************************************************
  // Modes
  // ************************************************************
  typedef enum logic [1:0] {
    EDGE_NONE,
    EDGE_FALL,
    EDGE_RISE,
    EDGE_BOTH
  } edge_sel_t;

  typedef enum logic [2:0] {
    OUT_PORT,
    OUT_TOGGLE,
    OUT_ZERO,
    OUT_ONE,
    OUT_PWM
  } out_mode_t;

  // ************************************************************
  // State records
  // ************************************************************
  typedef struct packed {
    logic prevLevel;
  } edge_state_t;

  typedef struct packed {
    logic [7:0] count;
    logic [3:0] loadLow;
    logic [3:0] loadHigh;
    logic [3:0] modeSel;
    logic [3:0] modePend;
    logic [1:0] pendCnt;
    logic [3:0] outCapMode;
    logic [3:0] pinFunc;
    logic [3:0] edgeSel;
    logic irqFlag;
    logic capStatus;
    logic capError;
    logic [7:0] captured;
    logic [3:0] lowLatch;
    logic [7:0] duty;
    logic outLevel;
    logic wrPend;
    logic [7:0] wrIdx;
    logic [31:0] rdata;
  } timer_state_t;

endpackage

// [rtl/event_edge_detect.sv]
// Edge detector for the event and trigger pin.
// Assumes the pin is already synchronous to clk.
`timescale 1ns/1ns
`include "timer_d_consts.svh"

module event_edge_detect
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic pinLevel,
  input wire logic enable,
  input wire timer_d_pkg::edge_sel_t edgeSel,
  output logic edgePulse
);

  timer_d_pkg::edge_state_t state_q;
  timer_d_pkg::edge_state_t state_d;
  logic fell;
  logic rose;

  // ************************************************************
  // Edge decode
  // ************************************************************
  always_comb
  begin
    state_d = state_q;
    state_d.prevLevel = pinLevel;
    fell = state_q.prevLevel & ~pinLevel;
    rose = ~state_q.prevLevel & pinLevel;
    edgePulse = 1'b0;
    if (enable)
    begin
      unique case (edgeSel)
        timer_d_pkg::EDGE_NONE: edgePulse = 1'b0;
        timer_d_pkg::EDGE_FALL: edgePulse = fell;
        timer_d_pkg::EDGE_RISE: edgePulse = rose;
        timer_d_pkg::EDGE_BOTH: edgePulse = fell | rose;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      state_q <= '0;
    else
      state_q <= state_d;
  end

endmodule

// [rtl/timer_d_capture_counter.sv]
// 8-bit reload, event and capture timer with an output pin, AHB-Lite slave.
// Assumes one clock, a prescaler tick input and a synchronous event pin.
//
// Notes on behaviour
// - Counter loads from write value, counts selected clocks, overflows at max.
// - Overflow reloads the write value, or restarts from zero when free-running.
// - Each overflow sets the interrupt request flag, bit 0, until cleared.
// - Event mode counts the event pin, once software assigns the pin.
// - Event edge is falling, rising or both, per edge select register.
// - Event mode adds one per detected edge; overflow handling is unchanged.
// - Second mode register picks toggle, low, high or PWM and takes pin.
// - Reset drives the timer output low.
// - Toggle mode inverts the output on a clock at maximum count.
// - Forced-low mode drives low on a clock at maximum count.
// - Forced-high mode drives high on a clock at maximum count.
// - Low digit written first and held; high digit write loads counter.
// - Capture edge copies count, sets interrupt and status flags, clears count.
// - In capture mode, trigger or overflow while status set raises the error flag, bit 1.
// - Status and error flags clear on reset or on a zero write.
// - Entering capture mode releases the pin and clears the counter.
// - Capture edge uses the same edge select register.
// - First mode register is write-only, resets zero, applies writes late.
// - Second mode register is read/write, holds output mode and capture.
// - Captured digits read in either order without corruption.
`timescale 1ns/1ns
`include "timer_d_consts.svh"

module timer_d_capture_counter
(
  input wire logic clk,
  input wire logic reset_n,
  input wire timer_d_pkg::ahb_req_t ahbReq,
  output timer_d_pkg::ahb_rsp_t ahbRsp,
  input wire logic prescaleTick,
  input wire logic eventTriggerPin,
  output logic timerOutputPin,
  output logic timerOutputSelect,
  output logic eventInputSelect,
  output logic timerIrqFlag
);

  timer_d_pkg::timer_state_t state_q;
  timer_d_pkg::timer_state_t state_d;

  logic accept;
  logic [7:0] reqIdx;
  logic wordSize;
  logic edgePulse;
  logic pinIsEvent;
  logic extClock;
  logic reloadMode;
  logic captureMode;
  logic tick;
  logic trigger;
  logic overflow;
  logic [7:0] loadValue;
  logic [7:0] afterWrap;
  logic [3:0] wdata;
  logic [7:0] wIdx;
  logic doWrite;
  timer_d_pkg::out_mode_t outMode;
  timer_d_pkg::edge_sel_t edgeSel;

  // ************************************************************
  // Decodes
  // ************************************************************
  assign accept = ahbReq.hsel & ahbReq.htrans[1] & ahbReq.hready;
  assign reqIdx = ahbReq.haddr[9:2];
  assign wordSize = (ahbReq.hsize == 3'h2);
  assign pinIsEvent = state_q.pinFunc[`BIT_PIN_EVENT_INPUT];
  assign extClock = state_q.modeSel[`BIT_MODE_EXT_EVENT];
  assign reloadMode = state_q.modeSel[`BIT_MODE_RELOAD];
  assign captureMode = state_q.outCapMode[`BIT_CAPTURE_ENABLE];
  assign outMode = timer_d_pkg::out_mode_t'(state_q.outCapMode[2:0]);
  assign edgeSel = timer_d_pkg::edge_sel_t'(state_q.edgeSel[1:0]);
  assign loadValue = {state_q.loadHigh, state_q.loadLow};
  assign wdata = ahbReq.hwdata[3:0];
  assign wIdx = state_q.wrIdx;
  assign doWrite = state_q.wrPend;

  // ************************************************************
  // Event pin edges
  // ************************************************************
  event_edge_detect edgeDetect
  (
    .clk(clk),
    .reset_n(reset_n),
    .pinLevel(eventTriggerPin),
    .enable(pinIsEvent),
    .edgeSel(edgeSel),
    .edgePulse(edgePulse)
  );

  // ************************************************************
  // Clock source and events
  // ************************************************************
  always_comb
  begin
    trigger = 1'b0;
    if (captureMode)
    begin
      tick = prescaleTick;
      trigger = edgePulse;
    end
    else if (extClock)
      tick = edgePulse;
    else
      tick = prescaleTick;
    overflow = tick & (state_q.count == `COUNT_MAX);
    afterWrap = reloadMode ? loadValue : `RST_COUNT;
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb
  begin
    state_d = state_q;

    // Counting, lowest priority first
    if (overflow)
      state_d.count = afterWrap;
    else if (tick)
      state_d.count = state_q.count + 8'h01;

    if (trigger)
    begin
      state_d.captured = state_q.count;
      state_d.count = `RST_COUNT;
    end

    // Flags, set wins over a clear
    if (doWrite && wIdx == `IDX_IRQ_FLAG && !wdata[`BIT_IRQ_FLAG])
      state_d.irqFlag = 1'b0;
    if (doWrite && wIdx == `IDX_CAPTURE_FLAGS)
    begin
      if (!wdata[`BIT_CAPTURE_STATUS])
        state_d.capStatus = 1'b0;
      if (!wdata[`BIT_CAPTURE_ERROR])
        state_d.capError = 1'b0;
    end
    if (overflow || trigger)
      state_d.irqFlag = 1'b1;
    if (trigger)
      state_d.capStatus = 1'b1;
    if (captureMode && state_q.capStatus && (trigger || overflow))
      state_d.capError = 1'b1;

    // Output pin behaviour
    if (overflow)
    begin
      state_d.duty = loadValue;
      unique case (outMode)
        timer_d_pkg::OUT_TOGGLE: state_d.outLevel = ~state_q.outLevel;
        timer_d_pkg::OUT_ZERO: state_d.outLevel = 1'b0;
        timer_d_pkg::OUT_ONE: state_d.outLevel = 1'b1;
        default: state_d.outLevel = state_q.outLevel;
      endcase
    end
    if (outMode == timer_d_pkg::OUT_PWM && tick)
      state_d.outLevel = (state_d.count < state_q.duty);

    // Delayed first mode register
    if (state_q.pendCnt != 2'h0)
    begin
      state_d.pendCnt = state_q.pendCnt - 2'h1;
      if (state_q.pendCnt == 2'h1)
        state_d.modeSel = state_q.modePend;
    end

    // Register writes in the data phase
    if (doWrite)
    begin
      unique case (wIdx)
        `IDX_COUNT_MODE_SELECT:
        begin
          state_d.modePend = wdata;
          state_d.pendCnt = `MODE_DELAY_CYCLES;
        end
        `IDX_LOAD_LOW: state_d.loadLow = wdata;
        `IDX_LOAD_HIGH:
        begin
          state_d.loadHigh = wdata;
          state_d.count = {wdata, state_q.loadLow};
        end
        `IDX_OUTPUT_CAPTURE_MODE:
        begin
          state_d.outCapMode = wdata;
          if (wdata[`BIT_CAPTURE_ENABLE] && !captureMode)
            state_d.count = `RST_COUNT;
        end
        `IDX_EVENT_PIN_FUNCTION: state_d.pinFunc = wdata;
        `IDX_EVENT_EDGE_SELECT: state_d.edgeSel = wdata;
        default: state_d.wrIdx = state_q.wrIdx;
      endcase
    end

    // Address phase capture and read data
    state_d.wrPend = accept & ahbReq.hwrite & wordSize;
    state_d.wrIdx = reqIdx;
    state_d.rdata = 32'h0000_0000;
    if (accept && !ahbReq.hwrite)
    begin
      unique case (reqIdx)
        `IDX_IRQ_FLAG:
          state_d.rdata[`BIT_IRQ_FLAG] = state_q.irqFlag;
        `IDX_LOAD_LOW:
          state_d.rdata[3:0] = captureMode ? state_q.captured[3:0]
                                           : state_q.lowLatch;
        `IDX_LOAD_HIGH:
        begin
          if (captureMode)
            state_d.rdata[3:0] = state_q.captured[7:4];
          else
          begin
            state_d.rdata[3:0] = state_q.count[7:4];
            state_d.lowLatch = state_q.count[3:0];
          end
        end
        `IDX_OUTPUT_CAPTURE_MODE:
          state_d.rdata[3:0] = state_q.outCapMode;
        `IDX_CAPTURE_FLAGS:
        begin
          state_d.rdata[`BIT_CAPTURE_STATUS] = state_q.capStatus;
          state_d.rdata[`BIT_CAPTURE_ERROR] = state_q.capError;
        end
        default: state_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q <= '0;
      state_q.modeSel <= `RST_NIBBLE;
      state_q.outCapMode <= `RST_NIBBLE;
      state_q.count <= `RST_COUNT;
    end
    else
      state_q <= state_d;
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign ahbRsp.hrdata = state_q.rdata;
  assign ahbRsp.hreadyout = 1'b1;
  assign ahbRsp.hresp = 1'b0;
  assign timerOutputPin = state_q.outLevel;
  assign timerOutputSelect = !captureMode && outMode != timer_d_pkg::OUT_PORT
    && state_q.outCapMode[2:0] <= 3'h4;
  assign eventInputSelect = pinIsEvent;
  assign timerIrqFlag = state_q.irqFlag;

endmodule

// [tb/timer_d_capture_counter_monitor.sv]
// Port checks for the timer.
// Assumes word registers on AHB-Lite and one clock.
`timescale 1ns/1ns
`include "timer_d_consts.svh"

module timer_d_capture_counter_monitor
(
  input wire logic clk,
  input wire logic reset_n,
  input wire timer_d_pkg::ahb_req_t ahbReq,
  input wire timer_d_pkg::ahb_rsp_t ahbRsp,
  input wire logic prescaleTick,
  input wire logic eventTriggerPin,
  input wire logic timerOutputPin,
  input wire logic timerOutputSelect,
  input wire logic eventInputSelect,
  input wire logic timerIrqFlag
);
  // ******
  // Write tracking
  // ******
  logic [7:0] wr_q;
  logic [3:0] mode_q;
  logic ev_q;
  logic cause;
  assign cause = prescaleTick || (eventTriggerPin != ev_q);
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_q <= 8'hff;
      mode_q <= 4'h0;
      ev_q <= 1'b0;
    end
    else
    begin
      ev_q <= eventTriggerPin;
      wr_q <= (ahbReq.hsel && ahbReq.htrans[1] && ahbReq.hready &&
        ahbReq.hwrite) ? ahbReq.haddr[9:2] : 8'hff;
      if (wr_q == `IDX_OUTPUT_CAPTURE_MODE)
        mode_q <= ahbReq.hwdata[3:0];
    end
  end
  // ******
  // Properties
  // ******
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_out_reset;
    $rose(reset_n) |-> !timerOutputPin;
  endproperty
  a_out_reset: assert property (p_out_reset)
    else $error("output high after reset");
  property p_irq_hold;
    $fell(timerIrqFlag) |-> $past(wr_q) == `IDX_IRQ_FLAG;
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("irq flag fell without write");
  property p_irq_cause;
    $rose(timerIrqFlag) |-> $past(cause);
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("irq flag rose without clock");
  property p_out_sel;
    timerOutputSelect == (mode_q[2:0] != 3'h0 && mode_q[2:0] <= 3'h4
      && !mode_q[3]);
  endproperty
  a_out_sel: assert property (p_out_sel)
    else $error("output select wrong");
  property p_pin_cause;
    $changed(timerOutputPin) |-> $past(cause);
  endproperty
  a_pin_cause: assert property (p_pin_cause)
    else $error("output changed without clock");
  property p_force_low;
    $rose(timerOutputPin) |-> $past(mode_q[2:0]) != 3'h2;
  endproperty
  a_force_low: assert property (p_force_low)
    else $error("output rose in low mode");
  property p_force_high;
    $fell(timerOutputPin) |-> $past(mode_q[2:0]) != 3'h3;
  endproperty
  a_force_high: assert property (p_force_high)
    else $error("output fell in high mode");
  property p_pin_func;
    $changed(eventInputSelect) |-> $past(wr_q) == `IDX_EVENT_PIN_FUNCTION;
  endproperty
  a_pin_func: assert property (p_pin_func)
    else $error("event select changed without write");
endmodule

bind timer_d_capture_counter timer_d_capture_counter_monitor
  timer_d_capture_counter_monitor_i
(
  .clk(clk),
  .reset_n(reset_n),
  .ahbReq(ahbReq),
  .ahbRsp(ahbRsp),
  .prescaleTick(prescaleTick),
  .eventTriggerPin(eventTriggerPin),
  .timerOutputPin(timerOutputPin),
  .timerOutputSelect(timerOutputSelect),
  .eventInputSelect(eventInputSelect),
  .timerIrqFlag(timerIrqFlag)
);

// [tb/event_source_model.sv]
// Event and trigger source for the timer's event pin.
// Assumes callers start right after a rising clock edge.
`timescale 1ns/1ns

module event_source_model
(
  input wire logic clk,
  output logic pinLevel
);
  initial pinLevel = 1'b0;
  // Each edge followed by three cycles
  task automatic toggle(int n);
    repeat (n)
    begin
      pinLevel <= ~pinLevel;
      repeat (3) @(posedge clk);
    end
  endtask
endmodule

// [tb/timer_d_capture_counter_tb.sv]
// Self-checking bench for the timer.
// Assumes the event source model drives the event pin.
`timescale 1ns/1ns
`include "timer_d_consts.svh"

module timer_d_capture_counter_tb;
  localparam logic [31:0] A_IRQ = {22'h0, `IDX_IRQ_FLAG, 2'h0};
  localparam logic [31:0] A_M1 = {22'h0, `IDX_COUNT_MODE_SELECT, 2'h0};
  localparam logic [31:0] A_LO = {22'h0, `IDX_LOAD_LOW, 2'h0};
  localparam logic [31:0] A_HI = {22'h0, `IDX_LOAD_HIGH, 2'h0};
  localparam logic [31:0] A_M2 = {22'h0, `IDX_OUTPUT_CAPTURE_MODE, 2'h0};
  localparam logic [31:0] A_CF = {22'h0, `IDX_CAPTURE_FLAGS, 2'h0};
  localparam logic [31:0] A_PIN = {22'h0, `IDX_EVENT_PIN_FUNCTION, 2'h0};
  localparam logic [31:0] A_EDG = {22'h0, `IDX_EVENT_EDGE_SELECT, 2'h0};
  typedef struct packed { logic [3:0] mode; logic sel; } row_t;
  row_t rows [7] = '{'{4'h0, 1'b0}, '{4'h1, 1'b1}, '{4'h2, 1'b1},
    '{4'h3, 1'b1}, '{4'h4, 1'b1}, '{4'h5, 1'b0}, '{4'h9, 1'b0}};
  logic clk, reset_n, tick, pin, outPin, outSel, evSel, irq;
  timer_d_pkg::ahb_req_t req;
  timer_d_pkg::ahb_req_t bus;
  timer_d_pkg::ahb_rsp_t rsp;
  logic [31:0] rd;
  logic [7:0] cnt;
  int n_mismatch = 0;
  int n_compared = 0;
  always_comb
  begin
    bus = req;
    bus.hready = rsp.hreadyout;
  end
  timer_d_capture_counter timer_d_capture_counter_i
  (
    .clk(clk),
    .reset_n(reset_n),
    .ahbReq(bus),
    .ahbRsp(rsp),
    .prescaleTick(tick),
    .eventTriggerPin(pin),
    .timerOutputPin(outPin),
    .timerOutputSelect(outSel),
    .eventInputSelect(evSel),
    .timerIrqFlag(irq)
  );
  event_source_model event_source_model_i
  (
    .clk(clk),
    .pinLevel(pin)
  );
  // ******
  // Tasks
  // ******
  task automatic check(string name, logic [7:0] exp, logic [7:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s exp %h got %h", name, exp, got);
    end
  endtask
  task automatic op(logic [31:0] a, logic w, logic [31:0] d);
    req.hsel <= 1'b1;
    req.haddr <= a;
    req.htrans <= 2'h2;
    req.hwrite <= w;
    req.hsize <= 3'h2;
    do @(posedge clk); while (rsp.hreadyout !== 1'b1);
    req.htrans <= 2'h0;
    req.hwdata <= d;
    do @(posedge clk); while (rsp.hreadyout !== 1'b1);
    rd = rsp.hrdata;
    check("hresp", 8'h0, {7'h0, rsp.hresp});
  endtask
  task automatic ticks(int n);
    repeat (n)
    begin
      tick <= 1'b1;
      @(posedge clk);
    end
    tick <= 1'b0;
    @(posedge clk);
  endtask
  task automatic load(logic [7:0] v);
    op(A_LO, 1'b1, {28'h0, v[3:0]});
    op(A_HI, 1'b1, {28'h0, v[7:4]});
  endtask
  task automatic readCount(logic lowFirst);
    op(lowFirst ? A_LO : A_HI, 1'b0, 32'h0);
    cnt = lowFirst ? {4'h0, rd[3:0]} : {rd[3:0], 4'h0};
    op(lowFirst ? A_HI : A_LO, 1'b0, 32'h0);
    cnt = cnt | (lowFirst ? {rd[3:0], 4'h0} : {4'h0, rd[3:0]});
  endtask
  task automatic test_done;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ******
  // Stimulus
  // ******
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    #200000;
    n_mismatch++;
    test_done();
  end
  initial
  begin
    req = '0;
    tick = 1'b0;
    reset_n = 1'b0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    check("pin", 8'h0, {7'h0, outPin});
    op(A_M2, 1'b0, 32'h0);
    check("mode2", 8'h0, rd[7:0]);
    op(32'h200, 1'b0, 32'h0);
    check("unmapped", 8'h0, rd[7:0]);
    foreach (rows[i])
    begin
      op(A_M2, 1'b1, {28'h0, rows[i].mode});
      op(A_M2, 1'b0, 32'h0);
      check("mode2", {4'h0, rows[i].mode}, rd[7:0]);
      check("outSel", {7'h0, rows[i].sel}, {7'h0, outSel});
    end
    op(A_M2, 1'b1, 32'h1);
    op(A_M1, 1'b1, 32'h0);
    repeat (3) @(posedge clk);
    load(8'hfe);
    ticks(1);
    check("irq", 8'h0, {7'h0, irq});
    ticks(1);
    check("irq", 8'h1, {7'h0, irq});
    check("pin", 8'h1, {7'h0, outPin});
    readCount(1'b0);
    check("count", 8'h00, cnt);
    op(A_IRQ, 1'b1, 32'h0);
    @(posedge clk);
    check("irq", 8'h0, {7'h0, irq});
    op(A_M1, 1'b1, 32'h1);
    repeat (3) @(posedge clk);
    op(A_M2, 1'b1, 32'h2);
    load(8'hfe);
    ticks(2);
    check("pin", 8'h0, {7'h0, outPin});
    readCount(1'b0);
    check("count", 8'hfe, cnt);
    op(A_LO, 1'b1, 32'h3);
    readCount(1'b0);
    check("count", 8'hfe, cnt);
    op(A_M2, 1'b1, 32'h3);
    op(A_HI, 1'b1, 32'hf);
    ticks(13);
    check("pin", 8'h1, {7'h0, outPin});
    readCount(1'b0);
    check("count", 8'hf3, cnt);
    op(A_IRQ, 1'b1, 32'h0);
    op(A_M2, 1'b1, 32'h0);
    op(A_PIN, 1'b1, 32'h1);
    op(A_M1, 1'b1, 32'h2);
    repeat (3) @(posedge clk);
    check("evSel", 8'h1, {7'h0, evSel});
    for (int c = 1; c < 4; c++)
    begin
      op(A_EDG, 1'b1, c);
      load(8'h00);
      event_source_model_i.toggle(4);
      readCount(1'b0);
      check("events", (c == 3) ? 8'h4 : 8'h2, cnt);
    end
    op(A_M1, 1'b1, 32'h0);
    repeat (3) @(posedge clk);
    op(A_EDG, 1'b1, 32'h1);
    op(A_M2, 1'b1, 32'h8);
    ticks(5);
    event_source_model_i.toggle(2);
    check("irq", 8'h1, {7'h0, irq});
    op(A_CF, 1'b0, 32'h0);
    check("capflags", 8'h1, rd[7:0]);
    readCount(1'b1);
    check("captured", 8'h05, cnt);
    event_source_model_i.toggle(2);
    op(A_CF, 1'b0, 32'h0);
    check("capflags", 8'h3, rd[7:0]);
    op(A_CF, 1'b1, 32'h0);
    op(A_CF, 1'b0, 32'h0);
    check("capflags", 8'h0, rd[7:0]);
    op(A_M2, 1'b1, 32'h4);
    load(8'hfe);
    ticks(3);
    check("pwm", 8'h1, {7'h0, outPin});
    ticks(253);
    check("pwm", 8'h0, {7'h0, outPin});
    ticks(2);
    check("pwm", 8'h1, {7'h0, outPin});
    reset_n <= 1'b0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    check("pin", 8'h0, {7'h0, outPin});
    check("irq", 8'h0, {7'h0, irq});
    op(A_M2, 1'b0, 32'h0);
    check("mode2", 8'h0, rd[7:0]);
    test_done();
  end
endmodule
